// ==== bzd_decoder.sv ====
// Receive zero-suppression line decoder: B3ZS/HDB3 removal or AMI,
// violation and excess-zero detection, counters, flags, irq gating.
// Assumes symbols arrive synchronous to ref_clk with a bit enable,
// and the register master keeps the plain strobe protocol.
//
// Behaviour
// - E3 select bit chooses violation or E3-CV counting
// - E3 CV is two same-polarity violations
// - Select bit ignored outside E3 mode
// - Check format 0: zero(s) then violation
// - Check format 1: alternate signature polarity required
// - Decode format 0: zero(s) then violation
// - Decode format 1: alternate signature polarity required
// - First signature after reset taken plain
// - Decode disable gives plain AMI decoding
// - Status shows excess-zero count nonzero
// - Status shows violation count nonzero
// - Status shows live loss of signal
// - Flag latches on any signature seen
// - Flag latches on each excess-zero event
// - Flag latches when excess-zero count leaves zero
// - Flag latches on violation or E3 CV
// - Flag latches when violation count leaves zero
// - Flag latches on any loss-of-signal change
// - Irq needs own, summary and global enables
// - Sixteen-bit violation counter
// - Sixteen-bit excess-zero counter
`timescale 1ns/1ps
module bzd_decoder (
    input wire logic ref_clk, // 100 MHz core clock
    input wire logic rstn, // Chip reset, active low
    input wire bzd_pkg::bzd_line_s line_in, // Received bipolar symbol
    input wire logic los_in, // Live loss of signal
    input wire logic [1:0] port_line_mode, // Port line mode
    input wire logic port_reset_bit, // Port reset, synchronous
    input wire logic port_decoder_summary_enable, // Port summary enable
    input wire logic global_port_irq_enable, // Global per-port enable
    input wire logic [7:0] reg_addr, // Register byte address
    input wire logic [15:0] reg_wdata, // Write data
    input wire logic reg_wr, // Write strobe
    input wire logic reg_rd, // Read strobe
    output logic [15:0] reg_rdata, // Read data, cycle after strobe
    output bzd_pkg::bzd_dec_s dec_out, // Decoded data stream
    output logic irq_req // Interrupt request level
);
    import bzd_pkg::*;

    // ------------------------------------------------------------
    // Functions
    // ------------------------------------------------------------

    // Signature polarity gate: plain when format 0 or first one
    function automatic logic sig_accept(input logic fmt, input logic have,
                                        input logic last_pol, input logic pol);
        sig_accept = !fmt || !have || (pol != last_pol);
    endfunction : sig_accept

    // ------------------------------------------------------------
    // Reset synchroniser
    // ------------------------------------------------------------
    logic [1:0] rst_pipe_q; // Release pipeline
    wire logic rst_n = rst_pipe_q[1]; // Synchronised reset

    // Release reset through two flops
    always_ff @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            rst_pipe_q <= 2'h0;
        end else begin
            rst_pipe_q <= {rst_pipe_q[0], 1'b1};
        end
    end

    // ------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------
    logic [3:0] ctrl_q; // line_receive_control
    logic [5:0] ie_q; // line_receive_irq_enable
    logic [5:0] latch_q; // line_receive_status_latched
    logic [5:0] latch_set; // Hardware set events

    wire logic wr_ctrl = reg_wr && (reg_addr == BZD_OFF_CTRL);
    wire logic wr_ie = reg_wr && (reg_addr == BZD_OFF_IE);
    wire logic wr_latch = reg_wr && (reg_addr == BZD_OFF_LATCH);
    wire logic rd_vcnt = reg_rd && (reg_addr == BZD_OFF_VCNT);
    wire logic rd_zcnt = reg_rd && (reg_addr == BZD_OFF_ZCNT);

    wire logic e3_sel = ctrl_q[BZD_CTRL_E3CV_SEL];
    wire logic chk_fmt = ctrl_q[BZD_CTRL_CHK_FMT];
    wire logic dec_fmt = ctrl_q[BZD_CTRL_DEC_FMT];
    wire logic dec_dis = ctrl_q[BZD_CTRL_DEC_DIS];
    wire logic e3_mode = (port_line_mode == BZD_LM_E3);
    wire logic hdb3 = e3_mode; // E3 uses HDB3, others B3ZS
    wire logic use_cv = e3_mode && e3_sel;

    // Control and enable storage
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q <= BZD_CTRL_RESET;
            ie_q <= BZD_IE_RESET;
        end else begin
            if (wr_ctrl) ctrl_q <= reg_wdata[3:0];
            if (wr_ie) ie_q <= reg_wdata[5:0];
        end
    end

    // ------------------------------------------------------------
    // Symbol classification
    // ------------------------------------------------------------
    wire logic bit_en = line_in.bit_en;
    wire logic mark = line_in.pos ^ line_in.neg; // Both high reads as zero
    wire logic pol = line_in.pos; // 1 = positive mark

    logic mark_seen_q; // A mark since reset
    logic last_pol_q; // Polarity of last mark
    logic [1:0] zero_hist_q; // Previous two symbols were zero
    logic dec_have_q; // Decoder saw a signature
    logic dec_pol_q; // Decoder last signature polarity
    logic chk_have_q; // Checker saw a signature
    logic chk_pol_q; // Checker last signature polarity
    logic e3_have_q; // Pending error violation
    logic e3_pol_q; // Its polarity
    logic [2:0] zrun_q; // Raw zero run length
    logic [3:0] dly_q; // Decoding delay line

    // Bipolar violation: same polarity as the previous mark
    wire logic bpv = bit_en && mark && mark_seen_q && (pol == last_pol_q);
    wire logic zeros_ok = hdb3 ? (&zero_hist_q) : zero_hist_q[0];
    wire logic raw_sig = bpv && zeros_ok && !dec_dis;
    wire logic dec_sig = raw_sig &&
                         sig_accept(dec_fmt, dec_have_q, dec_pol_q, pol);
    wire logic chk_sig = raw_sig &&
                         sig_accept(chk_fmt, chk_have_q, chk_pol_q, pol);
    wire logic err_bpv = bpv && !chk_sig; // Violation not a codeword
    wire logic e3_cv = err_bpv && e3_have_q && (pol == e3_pol_q);
    wire logic viol_evt = use_cv ? e3_cv : err_bpv;
    wire logic [2:0] exz_thr = hdb3 ? BZD_EXZ_HDB3 : BZD_EXZ_B3ZS;
    wire logic exz_evt = bit_en && !mark &&
                         (zrun_q == exz_thr - 3'h1); // Run reaches threshold

    // Delay line input; a signature zeroes itself and its fill bits
    logic [3:0] dly_d;
    wire logic [3:0] sig_mask = hdb3 ? 4'hf : 4'h7;
    assign dly_d = dec_sig ? ({dly_q[2:0], mark} & ~sig_mask) :
                             {dly_q[2:0], mark};

    // Line history, signature memory and decode pipeline
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            mark_seen_q <= 1'b0;
            last_pol_q <= 1'b0;
            zero_hist_q <= 2'h0;
            dec_have_q <= 1'b0;
            dec_pol_q <= 1'b0;
            chk_have_q <= 1'b0;
            chk_pol_q <= 1'b0;
            e3_have_q <= 1'b0;
            e3_pol_q <= 1'b0;
            zrun_q <= 3'h0;
            dly_q <= 4'h0;
        end else if (port_reset_bit) begin
            // Port reset restarts plain first-signature handling
            mark_seen_q <= 1'b0;
            zero_hist_q <= 2'h0;
            dec_have_q <= 1'b0;
            chk_have_q <= 1'b0;
            e3_have_q <= 1'b0;
            zrun_q <= 3'h0;
            dly_q <= 4'h0;
        end else if (bit_en) begin
            if (mark) begin
                mark_seen_q <= 1'b1;
                last_pol_q <= pol;
            end
            zero_hist_q <= {zero_hist_q[0], !mark};
            if (dec_sig) begin
                dec_have_q <= 1'b1;
                dec_pol_q <= pol;
            end
            if (chk_sig) begin
                chk_have_q <= 1'b1;
                chk_pol_q <= pol;
            end
            // Pair error violations; a completed pair starts afresh
            if (err_bpv) begin
                e3_have_q <= !e3_cv;
                e3_pol_q <= pol;
            end
            if (mark) begin
                zrun_q <= 3'h0;
            end else if (zrun_q != exz_thr) begin
                zrun_q <= zrun_q + 3'h1;
            end
            dly_q <= dly_d;
        end
    end

    // ------------------------------------------------------------
    // Decoded output
    // ------------------------------------------------------------
    bzd_dec_s dec_q; // Registered output

    // Present the oldest delay stage once per received bit
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            dec_q <= '0;
        end else begin
            dec_q.valid <= bit_en && !port_reset_bit;
            dec_q.data <= bit_en ? dly_q[3] : 1'b0;
        end
    end

    assign dec_out = dec_q;

    // ------------------------------------------------------------
    // Counters
    // ------------------------------------------------------------
    logic [BZD_CNT_W-1:0] vcnt; // Violation count
    logic [BZD_CNT_W-1:0] zcnt; // Excess zero count
    logic viol_nz; // violation_nonzero_status
    logic exz_nz; // excess_zero_nonzero_status

    // Violation or E3 code violation counter
    bzd_event_cnt #(.W(BZD_CNT_W)) u_vcnt (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .clr(port_reset_bit),
        .inc(viol_evt),
        .rd_clr(rd_vcnt),
        .count(vcnt),
        .nonzero(viol_nz)
    );

    // Excess zero counter
    bzd_event_cnt #(.W(BZD_CNT_W)) u_zcnt (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .clr(port_reset_bit),
        .inc(exz_evt),
        .rd_clr(rd_zcnt),
        .count(zcnt),
        .nonzero(exz_nz)
    );

    // ------------------------------------------------------------
    // Status and latched flags
    // ------------------------------------------------------------
    logic exz_nz_q; // Previous excess-zero nonzero
    logic viol_nz_q; // Previous violation nonzero
    logic los_q; // Previous loss of signal
    wire logic [15:0] status = {12'h0, exz_nz, 1'b0, viol_nz, los_in};

    assign latch_set[BZD_LT_SIG] = dec_sig || chk_sig;
    assign latch_set[BZD_LT_EXZ] = exz_evt;
    assign latch_set[BZD_LT_EXZ_NZ] = exz_nz && !exz_nz_q;
    assign latch_set[BZD_LT_VIOL] = viol_evt;
    assign latch_set[BZD_LT_VIOL_NZ] = viol_nz && !viol_nz_q;
    assign latch_set[BZD_LT_LOS] = los_in != los_q;

    wire logic [5:0] latch_clr = wr_latch ? reg_wdata[5:0] : 6'h00;

    // Edge history and sticky flags; set wins over clear
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            exz_nz_q <= 1'b0;
            viol_nz_q <= 1'b0;
            los_q <= 1'b0;
            latch_q <= BZD_LT_RESET;
        end else if (port_reset_bit) begin
            exz_nz_q <= 1'b0;
            viol_nz_q <= 1'b0;
            los_q <= los_in;
            latch_q <= BZD_LT_RESET;
        end else begin
            exz_nz_q <= exz_nz;
            viol_nz_q <= viol_nz;
            los_q <= los_in;
            latch_q <= (latch_q & ~latch_clr) | latch_set;
        end
    end

    // Interrupt gate
    assign irq_req = (|(latch_q & ie_q)) && port_decoder_summary_enable &&
                     global_port_irq_enable;

    // ------------------------------------------------------------
    // Register read port
    // ------------------------------------------------------------
    logic [15:0] rdata_q; // Read data register
    wire logic [15:0] rdata_d =
        (reg_addr == BZD_OFF_CTRL) ? {12'h0, ctrl_q} :
        (reg_addr == BZD_OFF_STAT) ? status :
        (reg_addr == BZD_OFF_IE) ? {10'h0, ie_q} :
        (reg_addr == BZD_OFF_LATCH) ? {10'h0, latch_q} :
        (reg_addr == BZD_OFF_VCNT) ? vcnt :
        (reg_addr == BZD_OFF_ZCNT) ? zcnt : 16'h0; // Unmapped reads zero

    // Data stands only in the cycle after the strobe
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata_q <= 16'h0;
        end else begin
            rdata_q <= reg_rd ? rdata_d : 16'h0;
        end
    end

    assign reg_rdata = rdata_q;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    sequence viol_seen_s;
        !port_reset_bit && viol_evt && !rd_vcnt;
    endsequence
    sequence viol_flag_s;
        latch_q[BZD_LT_VIOL] && viol_nz;
    endsequence

    viol_count_a: assert property (viol_seen_s |=> viol_flag_s)
        else $error("violation not counted or flagged");
    e3_select_a: assert property (err_bpv && !e3_cv && use_cv && !port_reset_bit && !rd_vcnt
        |=> vcnt == $past(vcnt))
        else $error("single violation counted in E3 CV mode");
    b3zs_ignore_a: assert property (!e3_mode |-> viol_evt == err_bpv)
        else $error("E3 select acted outside E3 mode");
    first_sig_a: assert property (raw_sig && !dec_have_q |-> dec_sig)
        else $error("first signature not taken plain");
    fmt_alt_a: assert property (dec_fmt && dec_have_q && raw_sig && pol == dec_pol_q
        |-> !dec_sig)
        else $error("same polarity signature accepted");
    chk_alt_a: assert property (chk_fmt && chk_have_q && raw_sig && pol == chk_pol_q
        |-> err_bpv)
        else $error("non alternating signature not an error");
    ami_only_a: assert property (dec_dis |-> !dec_sig && !chk_sig)
        else $error("substitution removed in AMI mode");
    exz_nz_a: assert property (status[BZD_ST_EXZ_NZ] == (zcnt != 16'h0))
        else $error("excess zero status wrong");
    los_flag_a: assert property (!port_reset_bit && $changed(los_in)
        ##1 !port_reset_bit |-> latch_q[BZD_LT_LOS])
        else $error("loss of signal change not latched");
    flag_hold_a: assert property (latch_q[BZD_LT_SIG] && !port_reset_bit &&
        !(wr_latch && reg_wdata[BZD_LT_SIG]) |=> latch_q[BZD_LT_SIG])
        else $error("latched flag dropped without clear");
    irq_gate_a: assert property (irq_req |-> port_decoder_summary_enable &&
        global_port_irq_enable && |(latch_q & ie_q))
        else $error("interrupt raised while masked");
    sig_flag_a: assert property (dec_sig && !port_reset_bit
        |=> latch_q[BZD_LT_SIG])
        else $error("signature not latched");

endmodule : bzd_decoder

// ==== bzd_pkg.sv ====
// Package for the zero-suppression line decoder: register map,
// field positions, reset values, line modes and carrier structs.
// Assumes a 16-bit register port with byte offsets as below.
package bzd_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] BZD_OFF_CTRL = 8'h40; // line_receive_control
    localparam logic [7:0] BZD_OFF_STAT = 8'h44; // line_receive_status
    localparam logic [7:0] BZD_OFF_IE = 8'h48; // line_receive_irq_enable
    localparam logic [7:0] BZD_OFF_LATCH = 8'h4c; // line_receive_status_latched
    localparam logic [7:0] BZD_OFF_VCNT = 8'h50; // bipolar_violation_counter
    localparam logic [7:0] BZD_OFF_ZCNT = 8'h54; // excessive_zero_counter

    // ------------------------------------------------------------
    // Control fields
    // ------------------------------------------------------------
    localparam int BZD_CTRL_E3CV_SEL = 3; // e3_code_violation_select
    localparam int BZD_CTRL_CHK_FMT = 2; // violation_check_signature_format
    localparam int BZD_CTRL_DEC_FMT = 1; // decoder_signature_format
    localparam int BZD_CTRL_DEC_DIS = 0; // substitution_decode_disable
    localparam logic [3:0] BZD_CTRL_RESET = 4'h0; // All formats plain

    // ------------------------------------------------------------
    // Status, latched and enable fields
    // ------------------------------------------------------------
    localparam int BZD_ST_EXZ_NZ = 3; // excess_zero_nonzero_status
    localparam int BZD_ST_VIOL_NZ = 1; // violation_nonzero_status
    localparam int BZD_ST_LOS = 0; // Live loss of signal
    localparam int BZD_LT_SIG = 5; // signature_seen_latched
    localparam int BZD_LT_EXZ = 4; // excess_zero_event_latched
    localparam int BZD_LT_EXZ_NZ = 3; // excess_zero_nonzero_latched
    localparam int BZD_LT_VIOL = 2; // violation_event_latched
    localparam int BZD_LT_VIOL_NZ = 1; // violation_nonzero_latched
    localparam int BZD_LT_LOS = 0; // signal_loss_change_latched
    localparam logic [5:0] BZD_LT_RESET = 6'h00; // Flags clear
    localparam logic [5:0] BZD_IE_RESET = 6'h00; // All masked

    // ------------------------------------------------------------
    // Line modes and zero thresholds
    // ------------------------------------------------------------
    localparam logic [1:0] BZD_LM_E3 = 2'h1; // port_line_mode value for E3
    localparam logic [2:0] BZD_EXZ_B3ZS = 3'h3; // Zeros that make excess in B3ZS
    localparam logic [2:0] BZD_EXZ_HDB3 = 3'h4; // Zeros that make excess in HDB3
    localparam int BZD_CNT_W = 16; // Counter width

    // Receive line symbol from the recovery front end
    typedef struct packed {
        logic bit_en; // One recovered bit this cycle
        logic pos; // Positive mark
        logic neg; // Negative mark
    } bzd_line_s;

    // Decoded output stream
    typedef struct packed {
        logic valid; // One decoded bit this cycle
        logic data; // Decoded bit value
    } bzd_dec_s;

endpackage : bzd_pkg

// ==== bzd_event_cnt.sv ====
// Saturating event counter with clear on read and nonzero flag.
// Assumes one clock, a synchronised active-low reset and a
// synchronous clear for port reset.
`timescale 1ns/1ps
module bzd_event_cnt #(
    parameter int W = 16 // Counter width
) (
    input wire logic ref_clk, // Core clock
    input wire logic rst_n, // Synchronised reset, active low
    input wire logic clr, // Synchronous clear
    input wire logic inc, // Count one event
    input wire logic rd_clr, // Software read clears count
    output logic [W-1:0] count, // Current count
    output logic nonzero // Count holds one or more
);
    import bzd_pkg::*;

    // ------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------
    logic [W-1:0] cnt_q; // Count register
    logic [W-1:0] cnt_d; // Next count
    wire logic at_max = &cnt_q; // Saturation point

    // Read clear with a same-cycle event leaves one; never wraps
    assign cnt_d = rd_clr ? {{(W-1){1'b0}}, inc} :
                   (inc && !at_max) ? cnt_q + {{(W-1){1'b0}}, 1'b1} : cnt_q;

    // Register the count
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_q <= '0;
        end else if (clr) begin
            cnt_q <= '0;
        end else begin
            cnt_q <= cnt_d;
        end
    end

    assign count = cnt_q;
    assign nonzero = |cnt_q;

endmodule : bzd_event_cnt

// ==== bzd_frontend.sv ====
// Model of the receive recovery front end feeding the line decoder.
// Assumes the bench pushes symbol codes between clock edges.
`timescale 1ns/1ps
module bzd_frontend (
    input wire logic ref_clk, // Core clock
    output bzd_pkg::bzd_line_s line_out // Recovered symbol
);
    import bzd_pkg::*;
    int q[$]; // Pending codes: 0 zero, 1 positive, 2 negative
    // ----------------------------------------
    // Symbol drive
    // ----------------------------------------
    // Start with no symbol and no marks
    initial line_out = '0;
    // One queued symbol per cycle, idle lines toggle so nothing stale reads
    always @(posedge ref_clk) begin
        if (q.size() > 0) begin
            line_out <= '{1'b1, q[0] == 1, q[0] == 2};
            void'(q.pop_front());
        end else begin
            line_out <= '{1'b0, ~line_out.pos, ~line_out.neg};
        end
    end
endmodule : bzd_frontend

// ==== bzd_tb.sv ====
// Self-checking bench for the line decoder with a behavioural model.
// Assumes the front end model and the plain register strobe port.
`timescale 1ns/1ps
module testbench;
    import bzd_pkg::*;
    logic ref_clk = 1'b0;
    logic rstn = 1'b0;
    bzd_line_s line_in; // From the front end
    logic los_in = 1'b0;
    logic port_reset_bit = 1'b0;
    logic sum_en = 1'b0;
    logic glb_en = 1'b0;
    logic [1:0] port_line_mode = 2'h0;
    logic [7:0] reg_addr = 8'h00;
    logic [15:0] reg_wdata = 16'h0000;
    logic [15:0] reg_rdata;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic irq_req;
    bzd_dec_s dec_out;
    int n_errors = 0;
    int n_checks = 0;
    int cyc = 0;
    int sent[$]; // Expected decoded bits
    int nval = 0; // Decoded bits seen
    int lpol, zrun, spol, first, vcnt, zcnt, sigs, pend, ppol, hdb, e3cv, fmt, ami;
    logic [31:0] seed = 32'd29860;
    logic [31:0] x;
    int r[$];

    bzd_frontend FE (.ref_clk(ref_clk), .line_out(line_in));
    bzd_decoder DUT (.ref_clk(ref_clk), .rstn(rstn), .line_in(line_in), .los_in(los_in),
        .port_line_mode(port_line_mode), .port_reset_bit(port_reset_bit),
        .port_decoder_summary_enable(sum_en), .global_port_irq_enable(glb_en),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .dec_out(dec_out), .irq_req(irq_req));

    // ----------------------------------------
    // Clock, timeout, decoded stream check
    // ----------------------------------------
    initial forever #5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 20000) begin
            n_errors++;
            test_done();
        end
        if (dec_out.valid === 1'b1) begin
            nval++;
            if (nval > 4) chk(16'(dec_out.data), 16'(sent[nval - 5]), "decoded bit");
        end
    end

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : xs

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("Error %0t: %s got %h exp %h", $time, m, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask : wr

    // Read and compare; data stands in the cycle after the strobe
    task automatic rc(input logic [7:0] a, input logic [15:0] e);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, e, "register read");
    endtask : rc

    // Send one symbol and advance the model
    task automatic sym(input int s);
        @(negedge ref_clk);
        FE.q.push_back(s);
        if (s == 0) begin
            zrun++;
            if (zrun == 3 + hdb) zcnt++;
            sent.push_back(0);
        end else if (s == lpol && !ami && zrun >= 1 + hdb && (!fmt || first || s != spol)) begin
            sigs++;
            first = 0;
            spol = s;
            for (int i = 1; i <= 2 + hdb; i++) sent[sent.size() - i] = 0;
            sent.push_back(0);
        end else begin
            if (s == lpol && e3cv) begin
                vcnt += (pend && s == ppol);
                pend = !(pend && s == ppol);
                ppol = s;
            end else if (s == lpol) vcnt++;
            sent.push_back(1);
        end
        if (s != 0) lpol = s;
        if (s != 0) zrun = 0;
    endtask : sym

    task automatic drain();
        repeat (200) if (FE.q.size() > 0) @(posedge ref_clk);
        repeat (4) @(posedge ref_clk);
    endtask : drain

    // Port reset, prelude, symbols, then status, flags and counters
    task automatic scn(input logic [1:0] m, input logic [3:0] c, input int s[$]);
        wr(BZD_OFF_CTRL, {12'h0, c});
        port_line_mode <= m;
        @(posedge ref_clk);
        port_reset_bit <= 1'b1;
        @(posedge ref_clk);
        port_reset_bit <= 1'b0;
        @(negedge ref_clk);
        hdb = (m == BZD_LM_E3);
        ami = c[0];
        fmt = c[1];
        e3cv = c[3] && hdb;
        {lpol, zrun, pend, nval, first} = {32'd0, 32'd0, 32'd0, 32'd0, 32'd1};
        sent.delete();
        sym(1);
        sym(2);
        drain();
        rc(BZD_OFF_VCNT, 16'h0000);
        wr(BZD_OFF_LATCH, 16'h003f);
        {vcnt, zcnt, sigs} = {32'd0, 32'd0, 32'd0};
        foreach (s[i]) sym(s[i]);
        drain();
        rc(BZD_OFF_STAT, {12'h0, zcnt > 0, 1'b0, vcnt > 0, los_in});
        rc(BZD_OFF_LATCH, {10'h0, sigs > 0, zcnt > 0, zcnt > 0, vcnt > 0, vcnt > 0, 1'b0});
        rc(BZD_OFF_VCNT, 16'(vcnt));
        rc(BZD_OFF_ZCNT, 16'(zcnt));
        rc(BZD_OFF_STAT, {15'h0, los_in});
        $display("Test done: mode %0d ctrl %h", m, c);
    endtask : scn

    task automatic test_done();
        $display("Checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : test_done

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        repeat (4) @(posedge ref_clk);
        rstn <= 1'b1;
        repeat (4) @(posedge ref_clk);
        rc(BZD_OFF_CTRL, 16'h0000);
        rc(BZD_OFF_IE, 16'h0000);
        rc(BZD_OFF_LATCH, 16'h0000);
        // Random readback of control and enables, unmapped place
        repeat (4) begin
            x = xs();
            wr(BZD_OFF_CTRL, {12'h0, x[3:0]});
            rc(BZD_OFF_CTRL, {12'h0, x[3:0]});
            wr(BZD_OFF_IE, {10'h0, x[9:4]});
            rc(BZD_OFF_IE, {10'h0, x[9:4]});
        end
        wr(8'h60, 16'hffff);
        rc(8'h60, 16'h0000);
        repeat (48) r.push_back(int'(xs() % 3));
        scn(2'h0, 4'h1, r);
        scn(BZD_LM_E3, 4'h9, '{1, 1, 1});
        scn(BZD_LM_E3, 4'h1, '{1, 1, 1});
        scn(2'h0, 4'h9, '{1, 1, 1});
        for (int f = 0; f < 2; f++) begin
            scn(2'h0, {1'b0, f[0], f[0], 1'b0}, '{1, 0, 1, 2, 1, 0, 1});
            scn(BZD_LM_E3, {1'b0, f[0], f[0], 1'b0}, '{1, 0, 0, 1, 2, 1, 0, 0, 1});
        end
        // Loss of signal, flag clearing and interrupt gating
        wr(BZD_OFF_IE, 16'h0001);
        wr(BZD_OFF_LATCH, 16'h003f);
        for (int i = 0; i < 5; i++) begin
            sum_en <= i[0] | i[2];
            glb_en <= i[1] | i[2];
            los_in <= ~los_in;
            if (i == 4) wr(BZD_OFF_IE, 16'h003e);
            repeat (3) @(posedge ref_clk);
            #1 chk({15'h0, irq_req}, {15'h0, i == 3}, "irq gate");
            rc(BZD_OFF_STAT, {15'h0, los_in});
            rc(BZD_OFF_LATCH, 16'h0001);
            wr(BZD_OFF_LATCH, 16'h0000);
            rc(BZD_OFF_LATCH, 16'h0001);
            wr(BZD_OFF_LATCH, 16'h0001);
            rc(BZD_OFF_LATCH, 16'h0000);
        end
        $display("Test done: loss of signal and interrupts");
        test_done();
    end
endmodule : testbench
